// file: rtl/status_event_summary.v
// Status summary register group on classic Wishbone: condition, event and enable registers.
// Assumes a 32-bit Wishbone master on clk_i; text parsing happens in host software.
// Overview of operation
// R1: A read of the measurement summary condition register returns its live value; writes are ignored.
// R2: That condition value uses the same bit layout as the measurement summary event register.
// R3: Reading the operation event register returns it and then clears all its bits except those that rise in the clearing cycle.
// R4: Event values read out as the plain binary-weighted sum of set bits.
// R5: The operation enable register is read/write, resets to zero and is not kept anywhere.
// R6: The operation summary bit is set while any event bit and its enable bit are both set.
// R7: Host software converts #b, #h or decimal text to a binary word before writing.
// R8: The instrument summary bit of the operation event register latches when an instrument event meets its enable.
// R9: Event bits latch on their source and stay set until read and cleared.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "status_event_summary_regs.vh"
module status_event_summary #(
   parameter WIDTH = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output wire err_o,
   input wire [WIDTH-1:0] meas_cond_i,
   input wire [WIDTH-1:0] oper_cond_i,
   input wire [WIDTH-1:0] oinst_cond_i,
   output wire operation_summary_bit_o,
   output wire irq_o
);
   reg [WIDTH-1:0] oper_enable_reg;
   reg [WIDTH-1:0] oinst_enable_reg;
   reg [`SES_IRQ_WIDTH-1:0] irq_status_reg;
   reg [`SES_IRQ_WIDTH-1:0] irq_mask_reg;
   reg instrument_summary_bit_prev_reg;
   reg osb_prev_reg;
   wire [WIDTH-1:0] oper_event;
   wire [WIDTH-1:0] oinst_event;
   wire [WIDTH-1:0] oper_src;
   wire instrument_summary_bit;
   wire req;
   wire rd;
   wire wr;
   wire [`SES_IRQ_WIDTH-1:0] irq_set;
   reg [31:0] rdata;
   reg mapped;
   wire [WIDTH-1:0] instrument_summary_bit_vec;
   wire [WIDTH-1:0] oper_enabled;
   wire [WIDTH-1:0] oinst_enabled;
   wire [WIDTH-1:0] oper_enable_next;
   wire [WIDTH-1:0] oinst_enable_next;
   wire [`SES_IRQ_WIDTH-1:0] irq_status_next;
   wire [`SES_IRQ_WIDTH-1:0] irq_mask_next;
   wire rd_oper_event;
   wire rd_oinst_event;
   wire wr_oper_enable;
   wire wr_oinst_enable;
   wire wr_irq_mask;
   wire wr_irq_status;

   function [31:0] widen;
      input [WIDTH-1:0] v;
      begin
         widen = 32'h00000000;
         widen[WIDTH-1:0] = v;
      end
   endfunction

   function [WIDTH-1:0] merge;
      input [WIDTH-1:0] old;
      input [31:0] d;
      input [3:0] s;
      reg [31:0] t;
      begin
         t = widen(old);
         if (s[0])
            t[7:0] = d[7:0];
         if (s[1])
            t[15:8] = d[15:8];
         if (s[2])
            t[23:16] = d[23:16];
         if (s[3])
            t[31:24] = d[31:24];
         merge = t[WIDTH-1:0];
      end
   endfunction

   function addr_hit;
      input [7:0] a;
      input [7:0] target;
      begin
         addr_hit = (a == target);
      end
   endfunction

   function [`SES_IRQ_WIDTH-1:0] clear_set;
      input [`SES_IRQ_WIDTH-1:0] cur;
      input [`SES_IRQ_WIDTH-1:0] clr;
      input [`SES_IRQ_WIDTH-1:0] evt;
      begin
         // Set beats write-one-to-clear
         clear_set = (cur & ~clr) | evt;
      end
   endfunction

   // Single-cycle answer; ack drops the cycle after it is given
   assign req = cyc_i & stb_i & ~ack_o;
   assign rd = req & ~we_i;
   assign wr = req & we_i;
   assign err_o = 1'b0;

   assign rd_oper_event = rd & addr_hit(adr_i, `SES_ADDR_OPER_EVENT); // R3
   assign rd_oinst_event = rd & addr_hit(adr_i, `SES_ADDR_OINST_EVENT);
   assign wr_oper_enable = wr & addr_hit(adr_i, `SES_ADDR_OPER_ENABLE); // R5
   assign wr_oinst_enable = wr & addr_hit(adr_i, `SES_ADDR_OINST_ENABLE);
   // Mask and status live in byte lane zero only
   assign wr_irq_mask = wr & addr_hit(adr_i, `SES_ADDR_IRQ_MASK) & sel_i[0];
   assign wr_irq_status = wr & addr_hit(adr_i, `SES_ADDR_IRQ_STATUS) & sel_i[0];

   // Condition register has no write path
   assign oper_enable_next = wr_oper_enable ?
      merge(oper_enable_reg, dat_i, sel_i) : oper_enable_reg; // R5 R7
   assign oinst_enable_next = wr_oinst_enable ?
      merge(oinst_enable_reg, dat_i, sel_i) : oinst_enable_reg;
   assign irq_mask_next = wr_irq_mask ? dat_i[`SES_IRQ_WIDTH-1:0] : irq_mask_reg;
   assign irq_status_next = clear_set(irq_status_reg,
      wr_irq_status ? dat_i[`SES_IRQ_WIDTH-1:0] : {`SES_IRQ_WIDTH{1'b0}}, irq_set);

   assign oinst_enabled = oinst_event & oinst_enable_reg;
   assign instrument_summary_bit = |oinst_enabled; // R8
   // Instrument summary joins the operation sources as one more rising edge
   assign instrument_summary_bit_vec = {{(WIDTH-1){1'b0}}, instrument_summary_bit} << `SES_INSTRUMENT_SUMMARY_BIT_BIT; // R8
   assign oper_src = oper_cond_i | instrument_summary_bit_vec; // R8
   assign oper_enabled = oper_event & oper_enable_reg;
   assign operation_summary_bit_o = |oper_enabled; // R6

   event_latch #(.WIDTH(WIDTH)) u_oper (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(oper_src),
      .clear_i(rd_oper_event), // R3
      .event_o(oper_event)
   );

   event_latch #(.WIDTH(WIDTH)) u_oinst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(oinst_cond_i),
      .clear_i(rd_oinst_event),
      .event_o(oinst_event)
   );

   assign irq_set[`SES_IRQ_OSB_BIT] = operation_summary_bit_o & ~osb_prev_reg;
   assign irq_set[`SES_IRQ_INSTRUMENT_SUMMARY_BIT_BIT] = instrument_summary_bit & ~instrument_summary_bit_prev_reg;
   assign irq_o = |(irq_status_reg & irq_mask_reg);

   always @*
   begin
      rdata = 32'h00000000;
      mapped = 1'b1;
      case (adr_i)
         `SES_ADDR_MEAS_COND: rdata = widen(meas_cond_i); // R1 R2
         `SES_ADDR_OPER_EVENT: rdata = widen(oper_event); // R4
         `SES_ADDR_OPER_ENABLE: rdata = widen(oper_enable_reg); // R5
         `SES_ADDR_OINST_EVENT: rdata = widen(oinst_event); // R4
         `SES_ADDR_OINST_ENABLE: rdata = widen(oinst_enable_reg);
         `SES_ADDR_IRQ_STATUS: rdata[`SES_IRQ_WIDTH-1:0] = irq_status_reg;
         `SES_ADDR_IRQ_MASK: rdata[`SES_IRQ_WIDTH-1:0] = irq_mask_reg;
         `SES_ADDR_STATUS_BYTE: rdata[`SES_STB_OSB_BIT] = operation_summary_bit_o; // R6
         default: mapped = 1'b0;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end
      else
      begin
         ack_o <= req;
         // Unmapped reads return zero, unmapped writes are dropped
         if (rd)
            dat_o <= mapped ? rdata : 32'h00000000;
      end
   end

   // Enables come back to zero on every reset; nothing keeps them
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         oper_enable_reg <= `SES_ENABLE_RESET; // R5
         oinst_enable_reg <= `SES_ENABLE_RESET;
      end
      else
      begin
         oper_enable_reg <= oper_enable_next; // R5 R7
         oinst_enable_reg <= oinst_enable_next;
      end
   end

   // Status records rising summary levels, not the levels themselves
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status_reg <= {`SES_IRQ_WIDTH{1'b0}};
         irq_mask_reg <= {`SES_IRQ_WIDTH{1'b0}};
         instrument_summary_bit_prev_reg <= 1'b0;
         osb_prev_reg <= 1'b0;
      end
      else
      begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         instrument_summary_bit_prev_reg <= instrument_summary_bit;
         osb_prev_reg <= operation_summary_bit_o;
      end
   end
endmodule
`default_nettype wire

// file: rtl/status_event_summary_regs.vh
// Register offsets, field positions and reset values for the status summary register group.
// Included by the register group only; the event latch does not use it; definitions only.
`ifndef STATUS_EVENT_SUMMARY_REGS_VH
`define STATUS_EVENT_SUMMARY_REGS_VH
`define SES_ADDR_MEAS_COND 8'h00
`define SES_ADDR_OPER_EVENT 8'h04
`define SES_ADDR_OPER_ENABLE 8'h08
`define SES_ADDR_OINST_EVENT 8'h0c
`define SES_ADDR_OINST_ENABLE 8'h10
`define SES_ADDR_IRQ_STATUS 8'h14
`define SES_ADDR_IRQ_MASK 8'h18
`define SES_ADDR_STATUS_BYTE 8'h1c
`define SES_INSTRUMENT_SUMMARY_BIT_BIT 13
`define SES_ENABLE_RESET 16'h0000
`define SES_IRQ_OSB_BIT 0
`define SES_IRQ_INSTRUMENT_SUMMARY_BIT_BIT 1
`define SES_IRQ_WIDTH 2
`define SES_STB_OSB_BIT 7
`endif

// file: rtl/event_latch.v
// Sticky event register: bits latch on a rising source, cleared by a read.
// Assumes sources synchronous to clk_i; a clear pulse comes from the bus read.
`timescale 1ns/1ps
`default_nettype none
module event_latch #(
   parameter WIDTH = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] cond_i,
   input wire clear_i,
   output wire [WIDTH-1:0] event_o
);
   reg [WIDTH-1:0] cond_reg;
   reg [WIDTH-1:0] event_reg;
   wire [WIDTH-1:0] rise;
   assign rise = cond_i & ~cond_reg;
   assign event_o = event_reg;
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cond_reg <= {WIDTH{1'b0}};
         event_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         cond_reg <= cond_i;
         // New edge wins over the read clear so no event is lost
         event_reg <= (clear_i ? {WIDTH{1'b0}} : event_reg) | rise; // R3 R9
      end
   end
endmodule
`default_nettype wire

// file: tb/wb_host.sv
// Host model: classic Wishbone master issuing single cycles.
// Assumes a slave on clk_i that acks every request.
`timescale 1ns/1ps
`default_nettype none
module wb_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial
   begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end
   // Values arrive already binary; text prefixes are resolved before this
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      @(posedge clk_i);
      while (!ack_i) @(posedge clk_i);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Released data is scrambled so stale values never look valid
      dat_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: tb/status_event_summary_sva.sv
// Checker for the status group's bus and summary outputs.
// Bound to status_event_summary; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ses_checker #(
   parameter WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [WIDTH-1:0] meas_cond_i,
   input wire logic [WIDTH-1:0] oper_cond_i,
   input wire logic [WIDTH-1:0] oinst_cond_i,
   input wire logic operation_summary_bit_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence oper_rd;
      ack_o && !we_i && adr_i == 8'h04;
   endsequence
   // No source edge could land in the clearing cycle, neither direct nor via the summary
   sequence src_quiet;
      $past(oper_cond_i) == $past(oper_cond_i, 2) &&
      $past(oinst_cond_i, 2) == $past(oinst_cond_i, 3);
   endsequence
   ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   cond_read_a: assert property (ack_o && !we_i && adr_i == 8'h00 |->
      dat_o[WIDTH-1:0] == $past(meas_cond_i)) else $error("bad condition read");
   upper_zero_a: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
      else $error("upper bits set");
   reset_quiet_a: assert property ($fell(rst_i) |-> !operation_summary_bit_o && !irq_o)
      else $error("not quiet after reset");
   read_clear_a: assert property (oper_rd ##0 src_quiet |-> !operation_summary_bit_o)
      else $error("event not cleared");
   sticky_a: assert property ($fell(operation_summary_bit_o) |->
      $past(cyc_i && stb_i && (adr_i == 8'h04 || adr_i == 8'h08))) else $error("summary lost");
   irq_hold_a: assert property ($fell(irq_o) |-> $past(cyc_i && stb_i && we_i))
      else $error("irq lost");
   status_byte_a: assert property (ack_o && !we_i && adr_i == 8'h1c |->
      dat_o[7] == $past(operation_summary_bit_o)) else $error("bad status byte");
endmodule
bind status_event_summary ses_checker #(.WIDTH(WIDTH)) i_ses_checker (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
   .ack_o(ack_o), .meas_cond_i(meas_cond_i), .oper_cond_i(oper_cond_i),
   .oinst_cond_i(oinst_cond_i),
   .operation_summary_bit_o(operation_summary_bit_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/status_event_summary_regs_tb.sv
// Bench for the status group: bus tasks, event pulses, expected values.
// Assumes wb_host as master; no long counts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module status_event_summary_regs_tb;
   logic clk = 0, rst = 1, cyc, stb, we, ack, err, operation_summary_bit, irq;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wd, rd_d, q;
   logic [15:0] meas = 0, oper = 0, oinst = 0;
   int n_mismatch = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   wb_host i_wb_host (.clk_i(clk), .ack_i(ack), .dat_i(rd_d), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
   status_event_summary i_status_event_summary (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd_d), .ack_o(ack),
      .err_o(err), .meas_cond_i(meas), .oper_cond_i(oper), .oinst_cond_i(oinst),
      .operation_summary_bit_o(operation_summary_bit), .irq_o(irq));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_wb_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      i_wb_host.xfer(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // Pulse then settle, so reads never race a fresh edge
   task automatic pulse(input int w, input logic [15:0] v);
      if (w) oinst <= v; else oper <= v;
      repeat (2) @(posedge clk);
      oper <= 0;
      oinst <= 0;
      repeat (4) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_mismatch++;
      end_sim;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(8'h08, 32'h0);
      wr(8'h08, 32'h2000);
      rd(8'h08, 32'h2000);
      meas <= 16'h0801;
      wr(8'h00, 32'hffff);
      rd(8'h00, 32'h0801);
      rd(8'h20, 32'h0);
      `CHK(err, 1'b0)
      pulse(0, 16'h2000);
      `CHK(operation_summary_bit, 1'b1)
      rd(8'h1c, 32'h80);
      rd(8'h04, 32'h2000);
      rd(8'h04, 32'h0);
      `CHK(operation_summary_bit, 1'b0)
      pulse(0, 16'h2000);
      `CHK(irq, 1'b0)
      wr(8'h18, 32'h1);
      `CHK(irq, 1'b1)
      wr(8'h14, 32'h1);
      `CHK(irq, 1'b0)
      rd(8'h04, 32'h2000);
      rd(8'h1c, 32'h0);
      // Event now clear; bit 13 can only return through the summary path
      wr(8'h10, 32'h0110);
      rd(8'h10, 32'h0110);
      pulse(1, 16'h0010);
      `CHK(irq, 1'b1)
      rd(8'h14, 32'h3);
      rd(8'h18, 32'h1);
      rd(8'h1c, 32'h80);
      rd(8'h0c, 32'h0010);
      rd(8'h04, 32'h2000);
      rd(8'h04, 32'h0);
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(8'h08, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      `CHK(irq, 1'b0)
      end_sim;
   end
endmodule
`default_nettype wire
